// *** shared/uhpc_pkg.sv ***
`default_nettype none
package uhpc_pkg;
	// Clock and timing
	localparam int CLK_MHZ       = 10;       // MCLK rate in MHz
	localparam int FRAME_US      = 1000;     // USB frame period in us
	localparam int FRAME_CYCLES  = FRAME_US * CLK_MHZ;
	localparam int ATTACH_NS     = 2500;     // Line must hold this long
	localparam int ATTACH_CYCLES = (ATTACH_NS * CLK_MHZ + 999) / 1000;
	// Root hub
	localparam int NUM_PORTS     = 2;
	localparam logic [7:0] PORT_COUNT_VAL = 8'h02;
	// Descriptor sizes in 32-bit words
	localparam int ED_WORDS      = 4;
	localparam int TD_WORDS      = 4;
	localparam int TD_ISO_WORDS  = 8;
	// Shared communication area layout
	localparam logic [31:0] COMM_BASE_MASK = 32'hffffff00;
	localparam logic [31:0] COMM_FRAME_OFS = 32'h00000080;
	localparam logic [31:0] COMM_DONE_OFS  = 32'h00000084;
	// Descriptor field offsets and positions
	localparam logic [31:0] PTR_MASK       = 32'hfffffff0;
	localparam logic [31:0] ED_HEAD_OFS    = 32'h00000008;
	localparam logic [31:0] TD_NEXT_OFS    = 32'h00000008;
	localparam int          ED_SKIP_BIT    = 14;
	localparam int          ED_ISO_BIT     = 15;
	localparam int          ED_HALT_BIT    = 0;
	localparam logic [31:0] TD_CC_MASK     = 32'hf0000000;
	localparam logic [31:0] TD_CC_NOERR    = 32'h00000000;
	// Reset values
	localparam logic [31:0] WORD_RST       = 32'h00000000;
	localparam logic [15:0] FRAME_RST      = 16'h0000;

	typedef enum logic [9:0] {
		ST_IDLE  = 10'h001,
		ST_HEAD  = 10'h002,
		ST_ED    = 10'h004,
		ST_TD    = 10'h008,
		ST_DATA  = 10'h010,
		ST_WTD   = 10'h020,
		ST_WED   = 10'h040,
		ST_WDONE = 10'h080,
		ST_WFRM  = 10'h100,
		ST_HALT  = 10'h200
	} uhpc_state_t;
endpackage
`default_nettype wire

// *** shared/uhpc_port_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// Status and control between one root hub port and the hub core
interface uhpc_port_if;
	logic conn;        // Device attached
	logic low_speed;   // Attached device is low speed
	logic change;      // One-cycle pulse on attach or detach
	logic bus_reset;   // Hub asks the port to drive SE0
	modport line (output conn, output low_speed, output change,
		input bus_reset);
	modport hub (input conn, input low_speed, input change,
		output bus_reset);
endinterface
`default_nettype wire

// *** rtl/uhpc_port.sv ***
`timescale 1ns/100ps
`default_nettype none
// One downstream root hub port: line watch and transceiver drive
module uhpc_port
	import uhpc_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   rst_b,
	uhpc_port_if.line   pif,
	input  wire logic   dp_in,
	input  wire logic   dm_in,
	output var  logic   dp_out,
	output var  logic   dp_oe,
	output var  logic   dm_out,
	output var  logic   dm_oe
);
	logic       dp_s1, dp_s2;       // Pin synchronisers
	logic       dm_s1, dm_s2;
	logic [7:0] cnt;                // Stable line time
	logic       conn, next_conn;
	logic       ls, next_ls;
	logic       chg, next_chg;
	logic [7:0] next_cnt;
	logic       idle_se0;

	// Attach seen as a pulled-up line held stable, detach as SE0 held
	always_comb begin
		idle_se0  = !dp_s2 && !dm_s2;
		next_cnt  = 8'h00;
		next_conn = conn;
		next_ls   = ls;
		next_chg  = 1'b0;
		if (pif.bus_reset) begin
			next_cnt = 8'h00;     // Own SE0 is not a detach
		end else if (conn == idle_se0) begin
			if (cnt == 8'(ATTACH_CYCLES - 1)) begin
				next_conn = !conn;
				next_ls   = dm_s2;  // Low speed pulls DM, full speed DP
				next_chg  = 1'b1;
			end else begin
				next_cnt = cnt + 8'h01;
			end
		end
	end

	// Registers only; first sync stage feeds nothing but the second
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dp_s1  <= 1'b0;
			dp_s2  <= 1'b0;
			dm_s1  <= 1'b0;
			dm_s2  <= 1'b0;
			cnt    <= 8'h00;
			conn   <= 1'b0;
			ls     <= 1'b0;
			chg    <= 1'b0;
			dp_oe  <= 1'b0;
			dm_oe  <= 1'b0;
			dp_out <= 1'b0;
			dm_out <= 1'b0;
		end else begin
			dp_s1  <= dp_in;
			dp_s2  <= dp_s1;
			dm_s1  <= dm_in;
			dm_s2  <= dm_s1;
			cnt    <= next_cnt;
			conn   <= next_conn;
			ls     <= next_ls;
			chg    <= next_chg;
			dp_oe  <= pif.bus_reset;  // Only the hub drives the pair
			dm_oe  <= pif.bus_reset;
			dp_out <= 1'b0;
			dm_out <= 1'b0;
		end
	end

	assign pif.conn      = conn;
	assign pif.low_speed = ls;
	assign pif.change    = chg;
endmodule
`default_nettype wire

// *** rtl/uhpc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Software reaches controller state as its target
// - Master fetches descriptors, moves data, retires
// - Abort or misalignment sets unrecoverable error
// - Port count readable by driver
// - Ports detect device attach by themselves
// - Only root hub ports drive transceivers
// - Register side and bus side share one clock
// - One interrupt line to system controller
// - Control, status and list pointers mapped
// - Base pointer locates shared area, we master
// - Shared area holds heads, done, frame
// - Endpoint four words, transfer four or eight
// - Endpoint owns a queue of transfers
// - Over-current input held inactive
// - Exactly two downstream ports
// - Low speed and full speed devices
module uhpc_top
	import uhpc_pkg::*;
#(
	parameter int FRAME_LEN = FRAME_CYCLES  // Cycles per frame
) (
	input  wire logic        MCLK,
	input  wire logic        RST_B,
	input  wire logic        HC_ENABLE,      // Run list processing
	input  wire logic [31:0] COMM_BASE,      // Shared area base
	input  wire logic [1:0]  PORT_RESET,     // Drive SE0 on a port
	input  wire logic        INT_ACK,        // Clear pending interrupt
	output var  logic        INT,
	output var  logic        UNRECOV_ERR,
	output var  logic [7:0]  PORT_COUNT,
	output var  logic [1:0]  PORT_CONN,
	output var  logic [1:0]  PORT_LS,
	output var  logic [15:0] FRAME_NUM,
	output var  logic [31:0] DATA_WORD,      // Last endpoint data read
	output var  logic        DMA_REQ,
	output var  logic        DMA_WRITE,
	output var  logic [31:0] DMA_ADDR,
	output var  logic [31:0] DMA_WDATA,
	input  wire logic        DMA_ACK,
	input  wire logic        DMA_ABORT,
	input  wire logic [31:0] DMA_RDATA,
	input  wire logic [1:0]  HDP_IN,
	input  wire logic [1:0]  HDM_IN,
	output wire logic [1:0]  HDP_OUT,
	output wire logic [1:0]  HDP_OE,
	output wire logic [1:0]  HDM_OUT,
	output wire logic [1:0]  HDM_OE
);
	uhpc_state_t state, next_state;      // List engine state
	logic [15:0] frame_cnt, next_frame_cnt;
	logic [15:0] frame, next_frame;
	logic        pend, next_pend;        // Frame start waiting
	logic [31:0] ed_ptr, next_ed_ptr;
	logic [31:0] td_ptr, next_td_ptr;
	logic [31:0] done_head, next_done_head;
	logic [31:0] ed_w [ED_WORDS];        // Fetched endpoint
	logic [31:0] next_ed_w [ED_WORDS];
	logic [31:0] td_w [TD_ISO_WORDS];    // Fetched transfer
	logic [31:0] next_td_w [TD_ISO_WORDS];
	logic [2:0]  widx, next_widx;        // Word index in descriptor
	logic        req, next_req;
	logic        wr, next_wr;
	logic [31:0] addr, next_addr;
	logic [31:0] wdata, next_wdata;
	logic [31:0] data_word, next_data_word;
	logic        uerr, next_uerr;
	logic        irq, next_irq;
	logic [31:0] base;                   // Aligned shared area base
	logic [31:0] acc_addr;               // Address of this access
	logic [31:0] acc_data;               // Data of this write
	logic        acc_wr;
	logic        acc_state;              // State does master accesses
	logic [2:0]  td_last;                // Last TD word index
	logic        port_evt;               // Any attach or detach
	logic        over_current;           // No pad, so never active
	logic [1:0]  conn_w, ls_w, chg_w;

	uhpc_port_if pif [NUM_PORTS] ();

	// Two ports, each with its own transceiver
	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++) begin : g_port
			assign pif[g].bus_reset = PORT_RESET[g];
			assign conn_w[g]        = pif[g].conn;
			assign ls_w[g]          = pif[g].low_speed;
			assign chg_w[g]         = pif[g].change;
			uhpc_port i_uhpc_port (
				.clk    (MCLK),
				.rst_b  (RST_B),
				.pif    (pif[g]),
				.dp_in  (HDP_IN[g]),
				.dm_in  (HDM_IN[g]),
				.dp_out (HDP_OUT[g]),
				.dp_oe  (HDP_OE[g]),
				.dm_out (HDM_OUT[g]),
				.dm_oe  (HDM_OE[g])
			);
		end
	endgenerate

	assign over_current = 1'b0;
	assign port_evt     = |chg_w;

	// Address and data of the access each state makes
	always_comb begin
		base     = COMM_BASE & COMM_BASE_MASK;
		acc_addr = WORD_RST;
		acc_data = WORD_RST;
		acc_wr   = 1'b0;
		acc_state = 1'b1;
		td_last  = ed_w[0][ED_ISO_BIT] ? 3'(TD_ISO_WORDS - 1)
			: 3'(TD_WORDS - 1);
		case (state)
			ST_HEAD:  acc_addr = base + {25'h0, frame[4:0], 2'b00};
			ST_ED:    acc_addr = ed_ptr + {27'h0, widx, 2'b00};
			ST_TD:    acc_addr = td_ptr + {27'h0, widx, 2'b00};
			ST_DATA:  acc_addr = td_w[1];
			ST_WTD: begin
				acc_wr = 1'b1;
				if (widx == 3'h0) begin
					// Completion code written as no error
					acc_addr = td_ptr;
					acc_data = (td_w[0] & ~TD_CC_MASK) | TD_CC_NOERR;
				end else begin
					// Retired TD links onto the done queue
					acc_addr = td_ptr + TD_NEXT_OFS;
					acc_data = done_head;
				end
			end
			ST_WED: begin
				acc_wr   = 1'b1;
				acc_addr = ed_ptr + ED_HEAD_OFS;
				acc_data = (td_w[2] & PTR_MASK) | (ed_w[2] & ~PTR_MASK);
			end
			ST_WDONE: begin
				acc_wr   = 1'b1;
				acc_addr = base + COMM_DONE_OFS;
				acc_data = done_head;
			end
			ST_WFRM: begin
				acc_wr   = 1'b1;
				acc_addr = base + COMM_FRAME_OFS;
				acc_data = {16'h0000, frame};
			end
			default:  acc_state = 1'b0;
		endcase
	end

	// List engine, frame timer and event flags
	always_comb begin
		next_state     = state;
		next_frame_cnt = frame_cnt + 16'h0001;
		next_frame     = frame;
		next_pend      = pend;
		next_ed_ptr    = ed_ptr;
		next_td_ptr    = td_ptr;
		next_done_head = done_head;
		next_ed_w      = ed_w;
		next_td_w      = td_w;
		next_widx      = widx;
		next_req       = req;
		next_wr        = wr;
		next_addr      = addr;
		next_wdata     = wdata;
		next_data_word = data_word;
		next_uerr      = uerr && HC_ENABLE;
		next_irq       = irq && !INT_ACK;
		// Frame boundary on a divided enable of the one clock
		if (frame_cnt == 16'(FRAME_LEN - 1)) begin
			next_frame_cnt = 16'h0000;
			next_frame     = frame + 16'h0001;
			next_pend      = 1'b1;
		end
		if (req) begin
			if (DMA_ABORT) begin
				next_req   = 1'b0;
				next_uerr  = 1'b1;
				next_state = ST_HALT;
			end else if (DMA_ACK) begin
				next_req = 1'b0;
				case (state)
					ST_HEAD: begin
						next_ed_ptr = DMA_RDATA & PTR_MASK;
						next_widx   = 3'h0;
						next_state  = ((DMA_RDATA & PTR_MASK) == WORD_RST)
							? ST_WFRM : ST_ED;
					end
					ST_ED: begin
						next_ed_w[widx[1:0]] = DMA_RDATA;
						next_widx = widx + 3'h1;
						if (widx == 3'(ED_WORDS - 1)) begin
							// Skip, halted or empty queue leaves the ED alone
							next_widx   = 3'h0;
							next_td_ptr = ed_w[2] & PTR_MASK;
							if (ed_w[0][ED_SKIP_BIT] || ed_w[2][ED_HALT_BIT]
								|| (ed_w[2] & PTR_MASK) == (ed_w[1] & PTR_MASK))
								next_state = ST_WFRM;
							else
								next_state = ST_TD;
						end
					end
					ST_TD: begin
						next_td_w[widx] = DMA_RDATA;
						next_widx = widx + 3'h1;
						if (widx == td_last) begin
							next_widx  = 3'h0;
							next_state = (td_w[1] == WORD_RST) ? ST_WTD : ST_DATA;
						end
					end
					ST_DATA: begin
						next_data_word = DMA_RDATA;
						next_state     = ST_WTD;
					end
					ST_WTD: begin
						next_widx = 3'h1;
						if (widx != 3'h0) begin
							next_done_head = td_ptr;
							next_widx      = 3'h0;
							next_state     = ST_WED;
						end
					end
					ST_WED:   next_state = ST_WDONE;
					ST_WDONE: begin
						next_irq   = 1'b1;
						next_state = ST_WFRM;
					end
					default:  next_state = ST_IDLE;
				endcase
			end
		end else if (acc_state) begin
			if (acc_addr[1:0] != 2'b00) begin
				next_uerr  = 1'b1;
				next_state = ST_HALT;
			end else begin
				// Master access issued in the order of the open model
				next_req   = 1'b1;
				next_wr    = acc_wr;
				next_addr  = acc_addr;
				next_wdata = acc_data;
			end
		end else if (state == ST_HALT) begin
			if (!HC_ENABLE)
				next_state = ST_IDLE;
		end else if (pend && HC_ENABLE && !over_current) begin
			next_pend  = 1'b0;
			next_state = ST_HEAD;
		end
		// Error and port events win over an acknowledge in the same cycle
		if (port_evt || (next_uerr && !uerr))
			next_irq = 1'b1;
	end

	// State registers only
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			state     <= ST_IDLE;
			frame_cnt <= FRAME_RST;
			frame     <= FRAME_RST;
			pend      <= 1'b0;
			ed_ptr    <= WORD_RST;
			td_ptr    <= WORD_RST;
			done_head <= WORD_RST;
			ed_w      <= '{default: WORD_RST};
			td_w      <= '{default: WORD_RST};
			widx      <= 3'h0;
			req       <= 1'b0;
			wr        <= 1'b0;
			addr      <= WORD_RST;
			wdata     <= WORD_RST;
			data_word <= WORD_RST;
			uerr      <= 1'b0;
			irq       <= 1'b0;
		end else begin
			state     <= next_state;
			frame_cnt <= next_frame_cnt;
			frame     <= next_frame;
			pend      <= next_pend;
			ed_ptr    <= next_ed_ptr;
			td_ptr    <= next_td_ptr;
			done_head <= next_done_head;
			ed_w      <= next_ed_w;
			td_w      <= next_td_w;
			widx      <= next_widx;
			req       <= next_req;
			wr        <= next_wr;
			addr      <= next_addr;
			wdata     <= next_wdata;
			data_word <= next_data_word;
			uerr      <= next_uerr;
			irq       <= next_irq;
		end
	end

	// Status outputs; port state is a copy so outputs stay registered
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			PORT_COUNT <= 8'h00;
			PORT_CONN  <= 2'b00;
			PORT_LS    <= 2'b00;
		end else begin
			PORT_COUNT <= PORT_COUNT_VAL;
			PORT_CONN  <= conn_w;
			PORT_LS    <= ls_w;
		end
	end

	// Direct register outputs; software side is target only
	assign INT         = irq;
	assign UNRECOV_ERR = uerr;
	assign FRAME_NUM   = frame;
	assign DATA_WORD   = data_word;
	assign DMA_REQ     = req;
	assign DMA_WRITE   = wr;
	assign DMA_ADDR    = addr;
	assign DMA_WDATA   = wdata;
endmodule
`default_nettype wire

// *** tb/uhpc_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
// Port-level watch on the host controller
module uhpc_checker (
	input wire logic        MCLK,
	input wire logic        RST_B,
	input wire logic        HC_ENABLE,
	input wire logic [1:0]  PORT_RESET,
	input wire logic        INT,
	input wire logic        UNRECOV_ERR,
	input wire logic [7:0]  PORT_COUNT,
	input wire logic [1:0]  PORT_CONN,
	input wire logic        DMA_REQ,
	input wire logic        DMA_WRITE,
	input wire logic [31:0] DMA_ADDR,
	input wire logic [31:0] DMA_WDATA,
	input wire logic        DMA_ACK,
	input wire logic        DMA_ABORT,
	input wire logic [1:0]  HDP_OUT,
	input wire logic [1:0]  HDP_OE,
	input wire logic [1:0]  HDM_OUT,
	input wire logic [1:0]  HDM_OE
);
	// One domain, so clock and reset are given once
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);

	req_hold_a: assert property (DMA_REQ && !DMA_ACK && !DMA_ABORT |=>
		DMA_REQ && $stable(DMA_ADDR) && $stable(DMA_WRITE)
		&& $stable(DMA_WDATA))
		else $error("master access changed before its answer");
	req_end_a: assert property (
		DMA_REQ && (DMA_ACK || DMA_ABORT) |=> !DMA_REQ)
		else $error("request held after its answer");
	abort_err_a: assert property (
		DMA_REQ && DMA_ABORT |=> UNRECOV_ERR && INT)
		else $error("abort did not raise the error flag");
	word_align_a: assert property (
		DMA_REQ |-> DMA_ADDR[1:0] == 2'h0)
		else $error("misaligned master access issued");
	err_clear_a: assert property (
		!HC_ENABLE && !DMA_REQ |=> !UNRECOV_ERR)
		else $error("error flag stayed while disabled");
	port_count_a: assert property (
		$past(RST_B) |-> PORT_COUNT == 8'h02)
		else $error("wrong port count");
	attach_int_a: assert property (
		$changed(PORT_CONN) |-> INT)
		else $error("attach change without interrupt");
	se0_drive_a: assert property (PORT_RESET != 2'h0 |=>
		(HDP_OE & HDM_OE & $past(PORT_RESET)) == $past(PORT_RESET))
		else $error("port reset did not drive the lines");
	line_low_a: assert property (
		HDP_OUT == 2'h0 && HDM_OUT == 2'h0)
		else $error("line driven to a non-SE0 level");
endmodule
`default_nettype wire

// *** tb/uhpc_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// System memory on the far side of the master bus
module uhpc_mem_model (
	input  wire logic        clk,
	input  wire logic        req,
	input  wire logic        wr,
	input  wire logic [31:0] addr,
	input  wire logic [31:0] wdata,
	output var  logic        ack,
	output var  logic        abort,
	output var  logic [31:0] rdata
);
	logic [31:0] mem [logic [31:0]];         // Sparse word store
	logic [31:0] bad_addr = 32'hffffffff;    // Access here aborts
	int          lat = 0;                    // Wait cycles per access
	int          cnt = 0;
	int          n_rd = 0;
	int          n_wr = 0;

	// Unwritten words read as the inverted address, a tidy zero only at 32'hffffffff
	function automatic logic [31:0] peek(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : ~a;
	endfunction

	// One endpoint with one transfer hanging from every frame slot
	function void load(input logic [31:0] ed0, input logic [31:0] head,
		input logic [31:0] bufp);
		mem.delete();
		for (int i = 0; i < 32; i++) begin
			mem[32'h1000 + 32'(4 * i)] = 32'h2000;
		end
		mem[32'h1080] = 32'hffffffff;
		mem[32'h1084] = 32'h0;
		mem[32'h2000] = ed0;
		mem[32'h2004] = 32'h3100;   // Tail differs from head
		mem[32'h2008] = head;
		mem[32'h3000] = 32'hf0000000;
		mem[32'h3004] = bufp;
		mem[32'h3008] = 32'h3100;
		mem[32'h4000] = 32'hcafe1234;
		n_rd = 0;
		n_wr = 0;
	endfunction

	initial begin
		ack = 1'b0;
		abort = 1'b0;
		rdata = 32'h0;
	end

	// Answer one access at a time, always just after the edge
	always @(posedge clk) begin
		#1;
		if (ack || abort) begin
			ack = 1'b0;             // Access over, answer withdrawn
			abort = 1'b0;
			rdata = ~rdata;         // Stale data must not look valid
		end else if (req && cnt < lat) begin
			cnt++;                  // Slow memory holds the master off
		end else if (req) begin
			cnt = 0;
			if (addr == bad_addr) begin
				abort = 1'b1;
			end else if (wr) begin
				mem[addr] = wdata;
				n_wr++;
				ack = 1'b1;
			end else begin
				rdata = peek(addr);
				n_rd++;
				ack = 1'b1;
			end
		end else begin
			rdata = ~rdata;
		end
	end
endmodule
`default_nettype wire

// *** tb/uhpc_top_test.sv ***
`timescale 1ns/100ps
`default_nettype none
// Bench for the host port controller
module uhpc_top_test import uhpc_pkg::*;;
	localparam int FL = 200;   // Short frame keeps the run brief
	logic        mclk, rst_b, hc_en, int_ack, irq, uerr;
	logic        dreq, dwr, dack, dabt;
	logic [31:0] base, daddr, dwd, drd, dword;
	logic [1:0]  prst, pconn, pls, hdp_out, hdp_oe, hdm_out, hdm_oe;
	logic [1:0]  dev_dp, dev_dm, hdp_in, hdm_in;
	logic [7:0]  pcnt;
	logic [15:0] fnum;
	int          num_errors = 0;
	int          n_checks = 0;

	// Host wins the wire while it drives, else the device level
	assign hdp_in = (hdp_oe & hdp_out) | (~hdp_oe & dev_dp);
	assign hdm_in = (hdm_oe & hdm_out) | (~hdm_oe & dev_dm);

	uhpc_top #(.FRAME_LEN(FL)) i_uhpc_top (.MCLK(mclk), .RST_B(rst_b),
		.HC_ENABLE(hc_en), .COMM_BASE(base), .PORT_RESET(prst),
		.INT_ACK(int_ack), .INT(irq), .UNRECOV_ERR(uerr),
		.PORT_COUNT(pcnt), .PORT_CONN(pconn), .PORT_LS(pls),
		.FRAME_NUM(fnum), .DATA_WORD(dword), .DMA_REQ(dreq),
		.DMA_WRITE(dwr), .DMA_ADDR(daddr), .DMA_WDATA(dwd),
		.DMA_ACK(dack), .DMA_ABORT(dabt), .DMA_RDATA(drd),
		.HDP_IN(hdp_in), .HDM_IN(hdm_in), .HDP_OUT(hdp_out),
		.HDP_OE(hdp_oe), .HDM_OUT(hdm_out), .HDM_OE(hdm_oe));
	uhpc_mem_model i_uhpc_mem_model (.clk(mclk), .req(dreq), .wr(dwr),
		.addr(daddr), .wdata(dwd), .ack(dack), .abort(dabt),
		.rdata(drd));

	always #50 mclk = ~mclk;

	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task summarize;
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task ack_int;
		int_ack = 1'b1;
		cyc(1);
		int_ack = 1'b0;
		cyc(1);
		chk(32'(irq), 32'h0);
	endtask

	// Enable until the frame number lands, the last write of a frame
	task frame_run;
		int k;
		hc_en = 1'b1;
		for (k = 0; k < 2 * FL + 100
			&& i_uhpc_mem_model.peek(32'h1080) === 32'hffffffff; k++) begin
			cyc(1);
		end
		hc_en = 1'b0;
		cyc(2);
	endtask

	// Plain, eight-word, skipped and halted endpoints, slower each time
	task t_frames;
		logic [31:0] ed0 [4] = '{32'h0, 32'h8000, 32'h4000, 32'h0};
		int          rd [4] = '{2 + ED_WORDS + TD_WORDS,
			2 + ED_WORDS + TD_ISO_WORDS, 1 + ED_WORDS, 1 + ED_WORDS};
		int          wr [4] = '{5, 5, 1, 1};
		for (int i = 0; i < 4; i++) begin
			// Other low byte in one pass; only the upper bits may count
			base = (i == 2) ? 32'h10fc : 32'h1055;
			i_uhpc_mem_model.load(ed0[i], i == 3 ? 32'h3001 : 32'h3000,
				32'h4000);
			i_uhpc_mem_model.lat = i;
			frame_run();
			chk(32'(i_uhpc_mem_model.n_rd), 32'(rd[i]));
			chk(32'(i_uhpc_mem_model.n_wr), 32'(wr[i]));
			chk(i_uhpc_mem_model.peek(32'h1080), 32'(fnum));
			if (i == 0) begin
				chk(dword, 32'hcafe1234);
				chk(i_uhpc_mem_model.peek(32'h3000) >> 28, 32'h0);
				chk(i_uhpc_mem_model.peek(32'h3008), 32'h0);
				chk(i_uhpc_mem_model.peek(32'h2008), 32'h3100);
				chk(i_uhpc_mem_model.peek(32'h1084), 32'h3000);
			end
		end
	endtask

	// Aborted endpoint read, then a misaligned data pointer
	task t_errors;
		int k;
		for (int i = 0; i < 2; i++) begin
			ack_int();
			i_uhpc_mem_model.load(32'h0, 32'h3000, i ? 32'h4002 : 32'h4000);
			i_uhpc_mem_model.bad_addr = i ? 32'hffffffff : 32'h2000;
			hc_en = 1'b1;
			for (k = 0; k < 2 * FL + 100 && uerr !== 1'b1; k++) begin
				cyc(1);
			end
			chk(32'({irq, uerr}), 32'h3);
			cyc(5);
			chk(32'(dreq), 32'h0);
			hc_en = 1'b0;
			cyc(2);
			chk(32'(uerr), 32'h0);
		end
		i_uhpc_mem_model.bad_addr = 32'hffffffff;
		ack_int();
	endtask

	// Blip, two attaches, SE0 drive with frozen watch, detach
	task t_attach;
		int k;
		dev_dp = 2'b01;
		cyc(10);
		dev_dp = 2'b00;
		cyc(40);
		chk(32'(pconn), 32'h0);
		dev_dp = 2'b01;   // Full-speed device on port 0
		dev_dm = 2'b10;   // Low-speed device on port 1
		for (k = 0; k < 60 && pconn !== 2'b11; k++) begin
			cyc(1);
		end
		chk(32'(k >= ATTACH_CYCLES && k <= ATTACH_CYCLES + 4), 32'h1);
		chk(32'({pconn, pls, irq}), 32'h1d);
		ack_int();
		prst = 2'b01;
		cyc(40);
		chk(32'({hdp_oe, hdm_oe, pconn}), 32'h17);
		prst = 2'b00;
		dev_dp = 2'b00;
		dev_dm = 2'b00;
		for (k = 0; k < 60 && pconn !== 2'b00; k++) begin
			cyc(1);
		end
		chk(32'({pconn, irq}), 32'h1);
	endtask

	initial begin
		mclk = 1'b0;
		rst_b = 1'b0;
		hc_en = 1'b0;
		base = 32'h1055;  // Low byte must be ignored
		prst = 2'b00;
		int_ack = 1'b0;
		dev_dp = 2'b00;
		dev_dm = 2'b00;
		cyc(20);
		chk(32'(pcnt), 32'h0);
		rst_b = 1'b1;
		cyc(1);
		chk(32'(pcnt), 32'h2);
		t_frames();
		t_errors();
		t_attach();
		summarize();
	end

	// Hang guard, far beyond the fewer than two thousand cycles needed
	initial begin
		#2000000;
		num_errors++;
		summarize();
	end
endmodule

bind uhpc_top uhpc_checker i_uhpc_checker (.MCLK(MCLK), .RST_B(RST_B),
	.HC_ENABLE(HC_ENABLE), .PORT_RESET(PORT_RESET), .INT(INT),
	.UNRECOV_ERR(UNRECOV_ERR), .PORT_COUNT(PORT_COUNT),
	.PORT_CONN(PORT_CONN), .DMA_REQ(DMA_REQ), .DMA_WRITE(DMA_WRITE),
	.DMA_ADDR(DMA_ADDR), .DMA_WDATA(DMA_WDATA), .DMA_ACK(DMA_ACK),
	.DMA_ABORT(DMA_ABORT), .HDP_OUT(HDP_OUT), .HDP_OE(HDP_OE),
	.HDM_OUT(HDM_OUT), .HDM_OE(HDM_OE));
`default_nettype wire
